/* File: shared/ulpcc_pkg.sv */
// constants and types for the ulpi command codec
package ulpcc_pkg;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  localparam logic [1:0] CODE_SPECIAL = 2'h0;
  localparam logic [1:0] CODE_TRANSMIT = 2'h1;
  localparam logic [1:0] CODE_REG_WRITE = 2'h2;
  localparam logic [1:0] CODE_REG_READ = 2'h3;
  localparam logic [5:0] PAYLOAD_NOPID = 6'h00;
  localparam logic [5:0] PAYLOAD_EXTENDED = 6'h2f;
  localparam logic [1:0] PID_ZERO_FIELD = 2'h0;
  localparam logic [1:0] XCVR_HIGH_SPEED = 2'h0;
  localparam logic [1:0] XCVR_LOW_SPEED = 2'h2;
  localparam logic [1:0] OPMODE_CHIRP = 2'h2;
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  localparam logic [1:0] LS_SE1 = 2'h3;
  localparam logic [1:0] VB_BELOW_END = 2'h0;
  localparam logic [1:0] VB_ABOVE_END = 2'h1;
  localparam logic [1:0] VB_SESS_VALID = 2'h2;
  localparam logic [1:0] VB_A_VALID = 2'h3;
  localparam logic [1:0] EV_NONE = 2'h0;
  localparam logic [1:0] EV_ACTIVE = 2'h1;
  localparam logic [1:0] EV_ERROR = 2'h3;
  localparam logic [1:0] EV_DISCONNECT = 2'h2;
  localparam int LINE_LSB = 0;
  localparam int VBUS_LSB = 2;
  localparam int EVENT_LSB = 4;
  localparam int ID_BIT = 6;
  localparam int ALT_BIT = 7;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [3:0] {
    CMD_NONE = 4'b0000,
    CMD_NOPID = 4'b0001,
    CMD_PID = 4'b0010,
    CMD_REG_WRITE = 4'b0011,
    CMD_EXT_WRITE = 4'b0100,
    CMD_REG_READ = 4'b0101,
    CMD_EXT_READ = 4'b0110,
    CMD_ILLEGAL = 4'b0111
  } ulpcc_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TURN_TO_LINK = 3'b001,
    ST_PAYLOAD = 3'b010,
    ST_EXT_ADDR = 3'b011,
    ST_STATUS = 3'b100,
    ST_TURN_TO_DEV = 3'b101
  } ulpcc_state_t;
endpackage

/* File: rtl/ulpcc_buffer.sv */
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/10ps
module ulpcc_buffer (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  input wire logic [7:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [7:0] out_data_out,
  input wire logic out_ready_in
);
  logic [7:0] mem [ulpcc_pkg::BUF_DEPTH];
  logic [1:0] count;
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] next_count;
  logic next_wr_ptr;
  logic next_rd_ptr;
  logic push;
  logic pop;
  logic next_out_valid;
  logic [7:0] next_out_data;

  always_comb begin
    push = in_valid_in && (count != 2'h2);
    pop = out_ready_in && (count != 2'h0);
    next_count = count + {1'b0, push} - {1'b0, pop};
    next_wr_ptr = wr_ptr ^ push;
    next_rd_ptr = rd_ptr ^ pop;
    in_ready_out = (count != 2'h2);
    // head of the buffer after this edge, registered for the output
    next_out_valid = (next_count != 2'h0);
    next_out_data = (push && wr_ptr == next_rd_ptr) ? in_data_in : mem[next_rd_ptr];
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= 2'h0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      out_valid_out <= 1'b0;
      out_data_out <= 8'h00;
    end else begin
      count <= next_count;
      out_valid_out <= next_out_valid;
      out_data_out <= next_out_data;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      if (push) begin
        mem[wr_ptr] <= in_data_in;
      end
    end
  end
endmodule

/* File: rtl/ulpcc_status_builder.sv */
// builds the status byte from line, vbus, event, id and alt sources
`timescale 1ns/10ps
module ulpcc_status_builder (
  input wire logic host_mode_in,
  input wire logic [1:0] xcvr_select_in,
  input wire logic term_select_in,
  input wire logic [1:0] op_mode_in,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic squelch_in,
  input wire logic hs_diff_in,
  input wire logic sess_end_in,
  input wire logic sess_valid_in,
  input wire logic a_valid_cmp_in,
  input wire logic fault_in,
  input wire logic use_ext_ind_in,
  input wire logic pass_through_in,
  input wire logic ind_complement_in,
  input wire logic rx_active_in,
  input wire logic rx_error_in,
  input wire logic host_disconnect_in,
  input wire logic id_in,
  input wire logic alt_int_in,
  output logic [7:0] status_out
);
  logic [1:0] line;
  logic [1:0] vbus;
  logic [1:0] event_code;
  logic a_valid;
  logic fault_level;
  logic hs_path;
  logic chirp;

  always_comb begin
    hs_path = (xcvr_select_in == ulpcc_pkg::XCVR_HIGH_SPEED);
    // chirp: peripheral by termination, host by opmode
    chirp = hs_path && (host_mode_in ? (op_mode_in == ulpcc_pkg::OPMODE_CHIRP)
                                     : term_select_in);
    if (chirp) begin
      line = squelch_in ? ulpcc_pkg::LS_SE0
           : (hs_diff_in ? ulpcc_pkg::LS_J : ulpcc_pkg::LS_K);
    end else if (hs_path) begin
      line = squelch_in ? ulpcc_pkg::LS_SE0 : ulpcc_pkg::LS_J;
    end else begin
      // dp high reads 01: full speed j, low speed k
      line = {dm_in, dp_in};
    end
    // external indicator may replace the comparator
    fault_level = fault_in ^ ind_complement_in;
    if (use_ext_ind_in && pass_through_in) begin
      a_valid = fault_level;
    end else if (use_ext_ind_in) begin
      a_valid = fault_level && a_valid_cmp_in;
    end else begin
      a_valid = a_valid_cmp_in;
    end
    if (a_valid) begin
      vbus = ulpcc_pkg::VB_A_VALID;
    end else if (sess_valid_in) begin
      vbus = ulpcc_pkg::VB_SESS_VALID;
    end else if (sess_end_in) begin
      vbus = ulpcc_pkg::VB_BELOW_END;
    end else begin
      vbus = ulpcc_pkg::VB_ABOVE_END;
    end
    if (host_mode_in && host_disconnect_in) begin
      event_code = ulpcc_pkg::EV_DISCONNECT;
    end else if (rx_active_in && rx_error_in) begin
      event_code = ulpcc_pkg::EV_ERROR;
    end else if (rx_active_in) begin
      event_code = ulpcc_pkg::EV_ACTIVE;
    end else begin
      event_code = ulpcc_pkg::EV_NONE;
    end
    status_out = 8'h00;
    status_out[ulpcc_pkg::LINE_LSB +: 2] = line;
    status_out[ulpcc_pkg::VBUS_LSB +: 2] = vbus;
    status_out[ulpcc_pkg::EVENT_LSB +: 2] = event_code;
    status_out[ulpcc_pkg::ID_BIT] = id_in;
    status_out[ulpcc_pkg::ALT_BIT] = alt_int_in;
  end
endmodule

/* File: rtl/ulpcc_codec.sv */
// ulpi command codec: transmit command decoder and status byte sender
// Summary of operation
// - nonzero command byte, device asserts nxt, data follows
// - code 00b payload zero is no operation
// - 01b zero payload: no-pid signalling after next byte
// - 01b 00xxxx: packet, pid from low nibble
// - 10b 101111: extended write, address byte follows
// - other 10b payloads: write, 6-bit immediate address
// - 11b 101111: extended read, address byte follows
// - other 11b payloads: read, 6-bit immediate address
// - status sent as one byte with dir high
// - any status field change sends new byte
// - wake-up status may be dropped if cleared
// - status byte field layout fixed
// - enabled b-valid edges send status with alt set
// - dp or dm change sends new line state
// - peripheral line state encoding per speed mode
// - host line state encoding per speed mode
// - vbus field encodes session comparators
// - a-valid selectable from indicator sources
// - pass-through fault drives a-valid, sends status
// - receive event field encoding
// - dir high: nxt low, data carries status
`timescale 1ns/10ps
module ulpcc_codec (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] ulpi_data_in,
  output logic [7:0] ulpi_data_out,
  output logic ulpi_data_oe_out,
  output logic ulpi_dir_out,
  output logic ulpi_nxt_out,
  input wire logic stp_in,
  input wire logic host_mode_in,
  input wire logic [1:0] xcvr_select_in,
  input wire logic term_select_in,
  input wire logic [1:0] op_mode_in,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic squelch_in,
  input wire logic hs_diff_in,
  input wire logic sess_end_in,
  input wire logic sess_valid_in,
  input wire logic a_valid_cmp_in,
  input wire logic fault_in,
  input wire logic use_ext_ind_in,
  input wire logic pass_through_in,
  input wire logic ind_complement_in,
  input wire logic rx_active_in,
  input wire logic rx_error_in,
  input wire logic host_disconnect_in,
  input wire logic id_in,
  input wire logic bvalid_in,
  input wire logic bvalid_rise_en_in,
  input wire logic bvalid_fall_en_in,
  input wire logic low_power_in,
  output logic [3:0] cmd_kind_out,
  output logic [7:0] cmd_addr_out,
  output logic [3:0] cmd_pid_out,
  output logic cmd_valid_out,
  output logic tx_byte_valid_out,
  output logic [7:0] tx_byte_out,
  input wire logic tx_byte_ready_in
);
  ulpcc_pkg::ulpcc_state_t state;
  ulpcc_pkg::ulpcc_state_t next_state;
  ulpcc_pkg::ulpcc_cmd_t cmd;
  ulpcc_pkg::ulpcc_cmd_t next_cmd;
  ulpcc_pkg::ulpcc_cmd_t decoded;
  logic [7:0] status_now;
  logic [7:0] status_sent;
  logic [7:0] next_status_sent;
  logic bvalid_prev;
  logic alt_pending;
  logic next_alt_pending;
  logic alt_event;
  logic status_due;
  logic [7:0] data_out;
  logic [7:0] next_data_out;
  logic data_oe;
  logic next_data_oe;
  logic dir;
  logic next_dir;
  logic nxt;
  logic next_nxt;
  logic first_beat;
  logic next_first_beat;
  logic [3:0] kind;
  logic [3:0] next_kind;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic [3:0] pid;
  logic [3:0] next_pid;
  logic valid;
  logic next_valid;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [7:0] buf_in_data;

  // decode a command byte into its kind
  function automatic ulpcc_pkg::ulpcc_cmd_t decode_cmd(input logic [7:0] b);
    logic [1:0] code;
    logic [5:0] payload;
    code = b[7:6];
    payload = b[5:0];
    unique case (code)
      ulpcc_pkg::CODE_SPECIAL: begin
        decode_cmd = (payload == ulpcc_pkg::PAYLOAD_NOPID) ? ulpcc_pkg::CMD_NONE
                   : ulpcc_pkg::CMD_ILLEGAL;
      end
      ulpcc_pkg::CODE_TRANSMIT: begin
        if (payload == ulpcc_pkg::PAYLOAD_NOPID) begin
          decode_cmd = ulpcc_pkg::CMD_NOPID;
        end else if (payload[5:4] == ulpcc_pkg::PID_ZERO_FIELD) begin
          decode_cmd = ulpcc_pkg::CMD_PID;
        end else begin
          decode_cmd = ulpcc_pkg::CMD_ILLEGAL;
        end
      end
      ulpcc_pkg::CODE_REG_WRITE: begin
        decode_cmd = (payload == ulpcc_pkg::PAYLOAD_EXTENDED) ? ulpcc_pkg::CMD_EXT_WRITE
                   : ulpcc_pkg::CMD_REG_WRITE;
      end
      ulpcc_pkg::CODE_REG_READ: begin
        decode_cmd = (payload == ulpcc_pkg::PAYLOAD_EXTENDED) ? ulpcc_pkg::CMD_EXT_READ
                   : ulpcc_pkg::CMD_REG_READ;
      end
    endcase
  endfunction

  ulpcc_status_builder u_status (
    .host_mode_in(host_mode_in),
    .xcvr_select_in(xcvr_select_in),
    .term_select_in(term_select_in),
    .op_mode_in(op_mode_in),
    .dp_in(dp_in),
    .dm_in(dm_in),
    .squelch_in(squelch_in),
    .hs_diff_in(hs_diff_in),
    .sess_end_in(sess_end_in),
    .sess_valid_in(sess_valid_in),
    .a_valid_cmp_in(a_valid_cmp_in),
    .fault_in(fault_in),
    .use_ext_ind_in(use_ext_ind_in),
    .pass_through_in(pass_through_in),
    .ind_complement_in(ind_complement_in),
    .rx_active_in(rx_active_in),
    .rx_error_in(rx_error_in),
    .host_disconnect_in(host_disconnect_in),
    .id_in(id_in),
    .alt_int_in(alt_pending),
    .status_out(status_now)
  );

  ulpcc_buffer u_buffer (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(buf_in_valid),
    .in_data_in(buf_in_data),
    .in_ready_out(buf_in_ready),
    .out_valid_out(tx_byte_valid_out),
    .out_data_out(tx_byte_out),
    .out_ready_in(tx_byte_ready_in)
  );

  always_comb begin
    decoded = decode_cmd(ulpi_data_in);
    // enabled b-valid edges raise the alternate flag
    alt_event = (bvalid_in && !bvalid_prev && bvalid_rise_en_in)
             || (!bvalid_in && bvalid_prev && bvalid_fall_en_in);
    next_alt_pending = alt_pending;
    if (alt_event) begin
      next_alt_pending = 1'b1;
    end
    // any field change, including line and fault, needs a status byte
    // while in low power nothing is sent; a change gone before wake is dropped
    status_due = (status_now != status_sent) && !low_power_in;
    next_state = state;
    next_status_sent = status_sent;
    next_cmd = cmd;
    next_dir = dir;
    next_nxt = 1'b0;
    next_first_beat = 1'b0;
    next_data_out = data_out;
    next_data_oe = data_oe;
    next_kind = kind;
    next_addr = addr;
    next_pid = pid;
    next_valid = 1'b0;
    buf_in_valid = 1'b0;
    buf_in_data = ulpi_data_in;
    unique case (state)
      ulpcc_pkg::ST_IDLE: begin
        // only decode with the bus owned by the link
        if (status_due) begin
          next_state = ulpcc_pkg::ST_TURN_TO_DEV;
          next_dir = 1'b1;
        end else if (ulpi_data_in != ulpcc_pkg::IDLE_BYTE
                     && decoded != ulpcc_pkg::CMD_ILLEGAL
                     && decoded != ulpcc_pkg::CMD_NONE) begin
          next_cmd = decoded; // accept and raise nxt
          next_nxt = 1'b1;
          // the first nxt edge takes the command byte itself
          next_first_beat = 1'b1;
          next_kind = decoded;
          next_pid = ulpi_data_in[3:0];
          next_addr = {2'b00, ulpi_data_in[5:0]};
          next_state = (decoded == ulpcc_pkg::CMD_EXT_WRITE
                        || decoded == ulpcc_pkg::CMD_EXT_READ)
                     ? ulpcc_pkg::ST_EXT_ADDR : ulpcc_pkg::ST_PAYLOAD;
          next_valid = !(decoded == ulpcc_pkg::CMD_EXT_WRITE
                         || decoded == ulpcc_pkg::CMD_EXT_READ);
        end
      end
      ulpcc_pkg::ST_EXT_ADDR: begin
        next_nxt = 1'b1;
        if (!first_beat) begin
          next_addr = ulpi_data_in; // full address byte
          next_valid = 1'b1;
          next_state = ulpcc_pkg::ST_PAYLOAD;
        end
      end
      ulpcc_pkg::ST_PAYLOAD: begin
        // data bytes go to the buffer; nxt drops when it cannot take one
        if (stp_in) begin
          next_state = ulpcc_pkg::ST_IDLE;
        end else if (cmd == ulpcc_pkg::CMD_REG_READ || cmd == ulpcc_pkg::CMD_EXT_READ) begin
          next_state = ulpcc_pkg::ST_IDLE;
        end else begin
          buf_in_valid = nxt && !first_beat;
          // keep nxt only while a slot is free after this edge
          next_nxt = buf_in_ready
                   && !(buf_in_valid && tx_byte_valid_out && !tx_byte_ready_in);
          if (!buf_in_ready && tx_byte_ready_in) begin
            next_nxt = 1'b1;
          end
        end
      end
      ulpcc_pkg::ST_TURN_TO_DEV: begin
        // turnaround cycle: data lines ignored
        next_data_oe = 1'b1;
        next_data_out = status_now;
        next_status_sent = status_now;
        next_alt_pending = alt_event;
        next_state = ulpcc_pkg::ST_STATUS;
      end
      ulpcc_pkg::ST_STATUS: begin
        // status byte on the bus with nxt low
        if (status_due) begin
          next_data_out = status_now;
          next_status_sent = status_now;
          next_alt_pending = alt_event;
        end else begin
          next_dir = 1'b0;
          next_data_oe = 1'b0;
          next_state = ulpcc_pkg::ST_TURN_TO_LINK;
        end
      end
      ulpcc_pkg::ST_TURN_TO_LINK: begin
        next_state = ulpcc_pkg::ST_IDLE; // turnaround cycle, then idle
      end
      default: begin
        next_state = ulpcc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ulpcc_pkg::ST_IDLE;
      cmd <= ulpcc_pkg::CMD_NONE;
      status_sent <= 8'h00;
      bvalid_prev <= 1'b0;
      alt_pending <= 1'b0;
      data_out <= 8'h00;
      data_oe <= 1'b0;
      dir <= 1'b0;
      nxt <= 1'b0;
      first_beat <= 1'b0;
      kind <= 4'h0;
      addr <= 8'h00;
      pid <= 4'h0;
      valid <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      status_sent <= next_status_sent;
      bvalid_prev <= bvalid_in;
      alt_pending <= next_alt_pending;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      dir <= next_dir;
      nxt <= next_nxt;
      first_beat <= next_first_beat;
      kind <= next_kind;
      addr <= next_addr;
      pid <= next_pid;
      valid <= next_valid;
    end
  end

  always_comb begin
    ulpi_data_out = data_out;
    ulpi_data_oe_out = data_oe;
    ulpi_dir_out = dir;
    ulpi_nxt_out = nxt;
    cmd_kind_out = kind;
    cmd_addr_out = addr;
    cmd_pid_out = pid;
    cmd_valid_out = valid;
  end
endmodule

/* File: tb/ulpcc_codec_assertions.sv */
// concurrent checks on the ulpi command codec ports
`timescale 1ns/10ps
module ulpcc_codec_checker (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] ulpi_data_in,
  input wire logic [7:0] ulpi_data_out,
  input wire logic ulpi_data_oe_out,
  input wire logic ulpi_dir_out,
  input wire logic ulpi_nxt_out,
  input wire logic id_in,
  input wire logic low_power_in,
  input wire logic [3:0] cmd_kind_out,
  input wire logic [7:0] cmd_addr_out,
  input wire logic [3:0] cmd_pid_out,
  input wire logic cmd_valid_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] prev_data;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) prev_data <= 8'h00;
    else prev_data <= ulpi_data_in;
  end
  sequence s_turn;
    !ulpi_data_oe_out ##1 ulpi_data_oe_out;
  endsequence
  sequence s_quiet;
    !ulpi_dir_out && ulpi_data_in == 8'h00 && !ulpi_nxt_out && !low_power_in;
  endsequence
  a_nxt_under_dir: assert property (ulpi_dir_out |-> !ulpi_nxt_out)
    else $error("nxt high while device owns bus");
  a_oe_needs_dir: assert property (ulpi_data_oe_out |-> ulpi_dir_out)
    else $error("data driven without dir");
  a_dir_turnaround: assert property ($rose(ulpi_dir_out) |-> s_turn)
    else $error("no turnaround cycle before status");
  a_id_status: assert property (s_quiet ##0 $changed(id_in) |-> ##[1:8] ulpi_data_oe_out)
    else $error("id change sent no status");
  a_id_bit: assert property (ulpi_data_oe_out && $stable(id_in) && $past(id_in, 2) == id_in
    |-> ulpi_data_out[6] == id_in)
    else $error("status id bit wrong");
  a_noop_ignored: assert property (cmd_valid_out |-> cmd_kind_out != 4'h0)
    else $error("idle byte decoded");
  a_pid_nibble: assert property (cmd_valid_out && cmd_kind_out == ulpcc_pkg::CMD_PID
    |-> cmd_pid_out == prev_data[3:0] && ulpi_nxt_out)
    else $error("pid or accept wrong");
  a_write_addr: assert property (cmd_valid_out && cmd_kind_out == ulpcc_pkg::CMD_REG_WRITE
    |-> cmd_addr_out == {2'b00, prev_data[5:0]})
    else $error("write address wrong");
  a_read_addr: assert property (cmd_valid_out && cmd_kind_out == ulpcc_pkg::CMD_REG_READ
    |-> cmd_addr_out == {2'b00, prev_data[5:0]})
    else $error("read address wrong");
  a_ext_addr: assert property (cmd_valid_out && (cmd_kind_out == ulpcc_pkg::CMD_EXT_WRITE
    || cmd_kind_out == ulpcc_pkg::CMD_EXT_READ) |-> cmd_addr_out == prev_data)
    else $error("extended address wrong");
endmodule
bind ulpcc_codec ulpcc_codec_checker u_checker (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out),
  .ulpi_data_oe_out(ulpi_data_oe_out), .ulpi_dir_out(ulpi_dir_out),
  .ulpi_nxt_out(ulpi_nxt_out), .id_in(id_in), .low_power_in(low_power_in),
  .cmd_kind_out(cmd_kind_out), .cmd_addr_out(cmd_addr_out), .cmd_pid_out(cmd_pid_out),
  .cmd_valid_out(cmd_valid_out));

/* File: tb/ulpcc_link_model.sv */
// link side model driving the ulpi bus towards the codec
`timescale 1ns/10ps
module ulpcc_link_model (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] bus_in,
  input wire logic dir_in,
  input wire logic nxt_in,
  input wire logic go_in,
  input wire logic [7:0] cmd_in,
  input wire logic [7:0] ext_in,
  input wire logic [2:0] n_in,
  output logic [7:0] data_out,
  output logic stp_out,
  output logic done_out,
  output logic [7:0] status_out,
  output logic [7:0] count_out
);
  logic busy;
  logic dir_d;
  logic [2:0] k;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'b0;
      dir_d <= 1'b0;
      k <= 3'h0;
      data_out <= 8'h00;
      stp_out <= 1'b0;
      done_out <= 1'b0;
      status_out <= 8'h00;
      count_out <= 8'h00;
    end else begin
      dir_d <= dir_in;
      done_out <= 1'b0;
      stp_out <= 1'b0;
      if (dir_in && dir_d) begin
        status_out <= bus_in;
        count_out <= count_out + 8'h01;
      end
      if (!busy && go_in && !dir_in) begin
        data_out <= cmd_in;
        k <= 3'h0;
        busy <= 1'b1;
      end else if (busy && nxt_in) begin
        if (k == n_in) begin
          data_out <= 8'h00;
          stp_out <= n_in != 3'h0;
          done_out <= 1'b1;
          busy <= 1'b0;
        end else begin
          data_out <= ext_in + 8'(k);
          k <= k + 3'h1;
        end
      end
    end
  end
endmodule

/* File: tb/ulpcc_codec_tb.sv */
// testbench for the ulpi command codec
`timescale 1ns/10ps
module ulpcc_codec_tb;
  logic clk, rst_n, oe, dir, nxt, stp, done, go, cv, tv, rdy, alt_seen;
  logic host, dp, dm, se, sv, av, flt, ue, pt, ra, re, hd, id, bv, bre, bfe, lp;
  logic [1:0] xcvr;
  logic [2:0] nb;
  logic [3:0] kind, pid, c_kind, c_pid;
  logic [7:0] bus, dout, ldata, st, scnt, cmd, ext, addr, tbyte, c_addr, n_cmd;
  logic [7:0] rxq[$];
  int mismatches, n_checks;
  assign bus = oe ? dout : (dir ? ~ldata : ldata);
  ulpcc_codec DUT (.core_clk_in(clk), .rst_n_in(rst_n), .ulpi_data_in(bus), .ulpi_data_out(dout),
    .ulpi_data_oe_out(oe), .ulpi_dir_out(dir), .ulpi_nxt_out(nxt), .stp_in(stp),
    .host_mode_in(host), .xcvr_select_in(xcvr), .term_select_in(1'b1), .op_mode_in(2'h0),
    .dp_in(dp), .dm_in(dm), .squelch_in(1'b0), .hs_diff_in(1'b0), .sess_end_in(se),
    .sess_valid_in(sv), .a_valid_cmp_in(av), .fault_in(flt), .use_ext_ind_in(ue),
    .pass_through_in(pt), .ind_complement_in(1'b0), .rx_active_in(ra), .rx_error_in(re),
    .host_disconnect_in(hd), .id_in(id), .bvalid_in(bv), .bvalid_rise_en_in(bre),
    .bvalid_fall_en_in(bfe), .low_power_in(lp), .cmd_kind_out(kind), .cmd_addr_out(addr),
    .cmd_pid_out(pid), .cmd_valid_out(cv), .tx_byte_valid_out(tv), .tx_byte_out(tbyte),
    .tx_byte_ready_in(rdy));
  ulpcc_link_model u_link (.core_clk_in(clk), .rst_n_in(rst_n), .bus_in(bus), .dir_in(dir),
    .nxt_in(nxt), .go_in(go), .cmd_in(cmd), .ext_in(ext), .n_in(nb), .data_out(ldata),
    .stp_out(stp), .done_out(done), .status_out(st), .count_out(scnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cv === 1'b1) begin
      c_kind <= kind;
      c_addr <= addr;
      c_pid <= pid;
      n_cmd <= n_cmd + 8'h01;
    end
    if (tv === 1'b1 && rdy === 1'b1) rxq.push_back(tbyte);
    if (oe === 1'b1 && dout[7] === 1'b1) alt_seen <= 1'b1;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [7:0] st_exp();
    logic [1:0] ls, vb, ev;
    logic a;
    ls = {dm, dp};
    a = ue ? (pt ? flt : flt & av) : av;
    vb = a ? 2'h3 : (sv ? 2'h2 : (se ? 2'h0 : 2'h1));
    ev = (host && hd) ? 2'h2 : (ra ? (re ? 2'h3 : 2'h1) : 2'h0);
    return {1'b0, id, ev, vb, ls};
  endfunction
  task automatic wait_status();
    logic [7:0] c;
    int k;
    c = scnt;
    k = 0;
    while (scnt == c && k < 40) begin
      @(posedge clk);
      k++;
    end
    check({7'h00, scnt != c}, 8'h01);
    repeat (6) @(posedge clk);
  endtask
  task automatic issue(input logic [7:0] c, input logic [7:0] e, input logic [2:0] n);
    int k;
    @(posedge clk);
    go <= 1'b1;
    cmd <= c;
    ext <= e;
    nb <= n;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 80) begin
      @(posedge clk);
      k++;
    end
    check({7'h00, done}, 8'h01);
    repeat (3) @(posedge clk);
  endtask
  task automatic test_reset_status();
    wait_status();
    check(st, st_exp());
    $display("test reset_status finished");
  endtask
  task automatic test_commands();
    logic [7:0] cb[6] = '{8'h41, 8'h40, 8'h85, 8'hc7, 8'haf, 8'hef};
    logic [3:0] kb[6] = '{ulpcc_pkg::CMD_PID, ulpcc_pkg::CMD_NOPID, ulpcc_pkg::CMD_REG_WRITE,
      ulpcc_pkg::CMD_REG_READ, ulpcc_pkg::CMD_EXT_WRITE, ulpcc_pkg::CMD_EXT_READ};
    logic [2:0] nt[6] = '{3'h1, 3'h1, 3'h1, 3'h0, 3'h2, 3'h1};
    logic [7:0] n0;
    n0 = n_cmd;
    repeat (20) @(posedge clk);
    check(n_cmd, n0);
    for (int i = 0; i < 6; i++) begin
      issue(cb[i], 8'h9a, nt[i]);
      check({4'h0, c_kind}, {4'h0, kb[i]});
      if (i == 0) check({4'h0, c_pid}, 8'h01);
      if (i > 1) check(c_addr, i < 4 ? {2'b00, cb[i][5:0]} : 8'h9a);
    end
    check(n_cmd - n0, 8'h06);
    $display("test commands finished");
  endtask
  task automatic test_buffer();
    rxq.delete();
    @(posedge clk);
    rdy <= 1'b0;
    fork
      issue(8'h43, 8'h30, 3'h4);
      begin
        repeat (14) @(posedge clk);
        check({7'h00, nxt}, 8'h00);
        rdy <= 1'b1;
      end
    join
    repeat (6) @(posedge clk);
    check(8'(rxq.size()), 8'h04);
    for (int i = 0; i < rxq.size(); i++) check(rxq[i], 8'h30 + 8'(i));
    $display("test buffer finished");
  endtask
  task automatic test_status();
    logic [2:0] vt[4] = '{3'b001, 3'b010, 3'b000, 3'b100};
    logic [2:0] et[4] = '{3'b010, 3'b011, 3'b100, 3'b010};
    logic [1:0] lt[4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {se, sv, av} <= vt[i];
      wait_status();
      check(st, st_exp());
      @(posedge clk);
      {hd, ra, re} <= et[i];
      wait_status();
      check(st, st_exp());
      @(posedge clk);
      {dp, dm} <= lt[i];
      wait_status();
      check(st, st_exp());
    end
    @(posedge clk);
    host <= 1'b1;
    xcvr <= 2'h2;
    hd <= 1'b1;
    {dp, dm} <= 2'b01;
    wait_status();
    check(st, st_exp());
    check({6'h00, st[1:0]}, 8'h02);
    check({6'h00, st[5:4]}, {6'h00, ulpcc_pkg::EV_DISCONNECT});
    @(posedge clk);
    id <= 1'b1;
    wait_status();
    check(st, st_exp());
    $display("test status finished");
  endtask
  task automatic test_alt();
    logic [3:0] at[4] = '{4'b1011, 4'b1000, 4'b0110, 4'b0101};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {bre, bfe, bv} <= at[i][3:1];
      alt_seen <= 1'b0;
      repeat (20) @(posedge clk);
      check({7'h00, alt_seen}, {7'h00, at[i][0]});
    end
    $display("test alt finished");
  endtask
  task automatic test_fault();
    @(posedge clk);
    ue <= 1'b1;
    pt <= 1'b1;
    repeat (8) @(posedge clk);
    flt <= 1'b1;
    wait_status();
    check(st, st_exp());
    @(posedge clk);
    flt <= 1'b0;
    wait_status();
    check(st, st_exp());
    $display("test fault finished");
  endtask
  task automatic test_low_power();
    logic [7:0] c;
    c = scnt;
    @(posedge clk);
    lp <= 1'b1;
    @(posedge clk);
    id <= ~id;
    repeat (20) @(posedge clk);
    check(scnt, c);
    $display("test low_power finished");
  endtask
  initial begin
    rst_n = 1'b0;
    {go, rdy, alt_seen, host, dp, dm, se, sv, av, flt, ue, pt} = 12'b0100_1010_0000;
    {ra, re, hd, id, bv, bre, bfe, lp} = 8'h00;
    xcvr = 2'h1;
    nb = 3'h0;
    cmd = 8'h00;
    ext = 8'h00;
    n_cmd = 8'h00;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    test_reset_status();
    test_commands();
    test_buffer();
    test_status();
    test_alt();
    test_fault();
    test_low_power();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
